// [bench/pwt_actuator.sv]
// Purpose: actuator model on the output channel, measures pulse shape
// Assumes: output is a plain push-pull level, sampled on clk_in
// Notes:   widths are cycles of the last completed high and low phase
`timescale 1ns/1ps
module pwt_actuator (
  input  wire logic        clk_in,        // system clock
  input  wire logic        clear_in,      // hold counts at zero
  input  wire logic        pwm_in,        // channel level
  output logic      [15:0] rise_cnt_out,  // rising edges seen
  output logic      [15:0] high_len_out,  // last high phase length
  output logic      [15:0] low_len_out    // last low phase length
);
  logic        pwm_r;
  logic [15:0] run_r;
  // run length counter; a phase is only reported once it has ended
  always_ff @(posedge clk_in) begin
    pwm_r <= pwm_in;
    if (clear_in) begin
      rise_cnt_out <= 16'h0000;
      high_len_out <= 16'h0000;
      low_len_out  <= 16'h0000;
      run_r        <= 16'h0000;
    end else if (pwm_in != pwm_r) begin
      run_r <= 16'h0001;
      if (pwm_r) high_len_out <= run_r;
      else low_len_out <= run_r;
      if (pwm_in) rise_cnt_out <= rise_cnt_out + 16'h0001;
    end else begin
      run_r <= run_r + 16'h0001;
    end
  end
endmodule : pwt_actuator

// [bench/tb_pwm_pulse_train_output.sv]
// Purpose: self-checking bench for the pwm / pulse train output unit
// Assumes: shortened time base, 20 clocks per 0.1ms unit, 40 per 1ms unit
// Notes:   apb master waits on pready; actuator model measures widths
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin fail_count++; \
  $display("[FAIL] %0t mismatch got %0h exp %0h", $time, got, exp); end end
module tb_pwm_pulse_train_output
  import pwt_pkg::*;
;
  logic        clk_in   = 1'b0;
  logic        reset_in = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, clear = 1'b1;
  logic [7:0]  paddr  = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rdat;
  logic        rerr, pready, pslverr, pwm, gate_st, cnt_dis;
  logic [2:0]  ctrl = 3'h0;
  logic [15:0] rises, hlen, llen;
  int          fail_count = 0, checks_done = 0;
  // clocks per unit in the shortened time bases handed to the design
  localparam int U_100US = 20;
  localparam int U_1MS   = 40;

  pwt_top #(.CYC_100US(16'(U_100US)), .CYC_1MS(16'(U_1MS))) DUT (
    .clk_in(clk_in), .reset_in(reset_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .pwm_out(pwm),
    .gate_state_out(gate_st), .count_disable_out(cnt_dis));
  pwt_actuator ACT (.clk_in(clk_in), .clear_in(clear), .pwm_in(pwm),
    .rise_cnt_out(rises), .high_len_out(hlen), .low_len_out(llen));

  // ------------------------------------------------------------
  // bus and job helpers
  // ------------------------------------------------------------
  // one idle edge before each setup so no signal is assigned twice per step;
  // ready, read data and error are all taken at the edge that ends the access
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_in);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk_in); n++; end while (pready !== 1'b1 && n < 50);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    `CHK(n < 50, 1'b1)
  endtask : apb

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h00000000);
  endtask : rd

  task automatic gate(input logic [2:0] c);
    ctrl = c;
    apb(1'b1, ADDR_CTRL, {29'h00000000, c});
  endtask : gate

  // the next job is only issued once done reads back high
  task automatic job(input logic [15:0] code, input logic [31:0] v);
    int n;
    apb(1'b1, ADDR_JCODE, {16'h0000, code});
    apb(1'b1, ADDR_JWVAL, v);
    apb(1'b1, ADDR_CTRL, {29'h00000000, ctrl | 3'h2});
    apb(1'b1, ADDR_CTRL, {29'h00000000, ctrl});
    n = 0;
    do begin rd(ADDR_STAT); n++; end while (rdat[STAT_DONE_BIT] !== 1'b1 && n < 20);
    `CHK(rdat[STAT_DONE_BIT], 1'b1)
  endtask : job

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    logic [15:0] cod [4] = '{16'h0081, 16'h0082, 16'h0084, 16'h008B};
    logic [15:0] exv [4] = '{PERIOD_RST, DELAY_RST, MINP_RST, {14'h0000, TB_RST}};
    rd(ADDR_STAT);
    `CHK(rdat, 32'h00000001)
    @(negedge clk_in);
    `CHK({pwm, gate_st, cnt_dis}, 3'h0)
    foreach (cod[i]) begin
      job(cod[i], 32'h00000000);
      rd(ADDR_JRVAL);
      `CHK(rdat[15:0], exv[i])
    end
  endtask : t_reset

  task automatic t_jobs();
    logic [15:0] cod [8] = '{16'h0001, 16'h0002, 16'h0004, 16'h000A,
                             16'h000B, 16'h000B, 16'h000B, 16'h000B};
    logic [15:0] val [8] = '{16'h000A, 16'h0003, 16'h0002, 16'h0006,
                             16'h0003, 16'h0002, 16'h0001, 16'h0000};
    foreach (cod[i]) begin
      job(cod[i], {16'h0000, val[i]});
      `CHK(rdat[STAT_ERR_BIT], 1'b0)
      job(cod[i] | JOB_RD_FLAG, 32'h00000000);
      rd(ADDR_JRVAL);
      `CHK(rdat[15:0], val[i])
    end
    // request held high: the second code must not be taken
    apb(1'b1, ADDR_JCODE, 32'h00000081);
    apb(1'b1, ADDR_CTRL, 32'h00000002);
    apb(1'b1, ADDR_JCODE, 32'h0000000C);
    apb(1'b1, ADDR_CTRL, 32'h00000002);
    rd(ADDR_STAT);
    `CHK(rdat[STAT_ERR_BIT], 1'b0)
    apb(1'b1, ADDR_CTRL, 32'h00000000);
  endtask : t_jobs

  task automatic t_fault();
    job(16'h000C, 32'h00000000);
    `CHK({rdat[STAT_ERR_BIT], rdat[31:16]}, {1'b1, FAULT_UNSUP})
    job(JOB_NOP, 32'h00000000);
    `CHK({rdat[STAT_ERR_BIT], rdat[31:16]}, {1'b0, FAULT_NONE})
    job(JOB_MINP, 32'h00000001);
    `CHK({rdat[STAT_ERR_BIT], rdat[31:16]}, {1'b1, FAULT_RANGE})
    job(JOB_PERIOD, 32'h00000000);
    `CHK({rdat[STAT_ERR_BIT], rdat[31:16]}, {1'b1, FAULT_RANGE})
    job(JOB_PERIOD, 32'h0000000A);
    `CHK({rdat[STAT_ERR_BIT], rdat[31:16]}, {1'b0, FAULT_NONE})
    apb(1'b1, 8'h20, 32'h12345678);
    rd(8'h20);
    `CHK({rerr, rdat}, {1'b1, 32'h00000000})
  endtask : t_fault

  // period 10 units, on-delay 3 units, half duty: 5 units high, 5 low, u clocks a unit;
  // the first delay unit is partial because the unit tick runs free
  task automatic t_pwm(input logic fmt, input logic [15:0] duty, input logic [1:0] tbc,
                       input int u);
    int n;
    job(JOB_TBASE, {30'h00000000, tbc});
    apb(1'b1, ADDR_DUTY, {16'h0000, duty});
    gate({fmt, 2'b01});
    clear <= 1'b0;
    n = 0;
    while (pwm !== 1'b1 && n < 200) begin @(negedge clk_in); n++; end
    `CHK(n >= 2 * u + 4 && n <= 3 * u + 5, 1'b1)
    `CHK({gate_st, cnt_dis}, 2'b11)
    rd(ADDR_STAT);
    `CHK({rdat[STAT_MODE_BIT], rdat[STAT_RUN_BIT], rdat[STAT_GATE_BIT]}, 3'b011)
    n = 0;
    while (rises < 16'h0003 && n < 2000) begin @(negedge clk_in); n++; end
    `CHK({n < 2000, hlen, llen}, {1'b1, 16'(5 * u), 16'(5 * u)})
    gate(3'h0);
    clear <= 1'b1;
    repeat (3) @(negedge clk_in);
    `CHK({pwm, gate_st, cnt_dis}, 3'h0)
    job(JOB_TBASE, {30'h00000000, TB_100US});
  endtask : t_pwm

  // 1 unit pulse is dropped, 1 unit pause turns into a steady high
  task automatic t_minp();
    logic [15:0] duty [2] = '{16'h0064, 16'h0384};
    int bad;
    foreach (duty[i]) begin
      apb(1'b1, ADDR_DUTY, {16'h0000, duty[i]});
      gate(3'h1);
      repeat (200) @(negedge clk_in);
      bad = 0;
      repeat (600) begin @(negedge clk_in); if (pwm !== 1'(i)) bad++; end
      `CHK(bad, 0)
      gate(3'h0);
    end
  endtask : t_minp

  // two periods of 10 units, then one of 6 units, then the channel rests
  task automatic t_train();
    job(JOB_CNT1, 32'h00000002);
    job(JOB_CNT2, 32'h00000001);
    job(JOB_CNT1 | JOB_RD_FLAG, 32'h00000000);
    rd(ADDR_JRVAL);
    `CHK(rdat, 32'h00000002)
    job(JOB_CNT2 | JOB_RD_FLAG, 32'h00000000);
    rd(ADDR_JRVAL);
    `CHK(rdat, 32'h00000001)
    apb(1'b1, ADDR_DUTY, 32'h000001F4);
    gate(3'h1);
    clear <= 1'b0;
    rd(ADDR_STAT);
    `CHK(rdat[STAT_MODE_BIT], 1'b1)
    repeat (1500) @(negedge clk_in);
    `CHK({rises, hlen, pwm}, {16'h0003, 16'h003C, 1'b0})
    gate(3'h0);
    clear <= 1'b1;
    job(JOB_CNT1, 32'h00000000);
    job(JOB_CNT2, 32'h00000000);
  endtask : t_train

  task automatic wrap_up();
    $display("checks %0d failures %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  // ------------------------------------------------------------
  // clock, sequence, watchdog
  // ------------------------------------------------------------
  initial forever #10 clk_in = ~clk_in;

  initial begin
    repeat (8) @(posedge clk_in);
    reset_in <= 1'b0;
    t_reset();
    t_jobs();
    t_fault();
    t_pwm(1'b0, 16'h01F4, TB_100US, U_100US);
    t_pwm(1'b1, 16'h3600, TB_1MS, U_1MS);
    t_minp();
    t_train();
    wrap_up();
  end

  // whole run takes about 5100 cycles; 20000 cycles cuts a hang short
  initial begin
    #400000;
    fail_count++;
    wrap_up();
  end
endmodule : tb_pwm_pulse_train_output

// [rtl/pwt_pkg.sv]
// Purpose: shared constants for the pulse width / pulse train output unit
// Assumes: 50 MHz clock, 32-bit APB register access
// Notes:   times are given in ns; cycle counts derive from the clock period
package pwt_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_DUTY  = 8'h04;
  localparam logic [7:0] ADDR_JCODE = 8'h08;
  localparam logic [7:0] ADDR_JWVAL = 8'h0C;
  localparam logic [7:0] ADDR_STAT  = 8'h10;
  localparam logic [7:0] ADDR_JRVAL = 8'h14;
  localparam int CTRL_GATE_BIT = 0;
  localparam int CTRL_REQ_BIT  = 1;
  localparam int CTRL_FMT_BIT  = 2;
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_ERR_BIT  = 1;
  localparam int STAT_GATE_BIT = 2;
  localparam int STAT_MODE_BIT = 3;
  localparam int STAT_RUN_BIT  = 4;
  localparam int STAT_FAULT_LSB = 16;
  // ---------------------------------------------------------------
  // duty scales, reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] SCALE_PERMIL = 16'h03E8;
  localparam logic [15:0] SCALE_ANALOG = 16'h6C00;
  localparam logic [15:0] PERIOD_RST   = 16'h4E20;
  localparam logic [15:0] MINP_RST     = 16'h0002;
  localparam logic [15:0] DELAY_RST    = 16'h0000;
  localparam logic [1:0]  TB_100US = 2'h0;
  localparam logic [1:0]  TB_1MS   = 2'h1;
  localparam logic [1:0]  TB_1US   = 2'h2;
  localparam logic [1:0]  TB_10US  = 2'h3;
  localparam logic [1:0]  TB_RST   = TB_100US;
  // ---------------------------------------------------------------
  // job codes and fault words
  // ---------------------------------------------------------------
  localparam logic [15:0] JOB_NOP     = 16'h0000;
  localparam logic [15:0] JOB_PERIOD  = 16'h0001;
  localparam logic [15:0] JOB_DELAY   = 16'h0002;
  localparam logic [15:0] JOB_MINP    = 16'h0004;
  localparam logic [15:0] JOB_CNT1    = 16'h0008;
  localparam logic [15:0] JOB_CNT2    = 16'h0009;
  localparam logic [15:0] JOB_PERIOD2 = 16'h000A;
  localparam logic [15:0] JOB_TBASE   = 16'h000B;
  localparam logic [15:0] JOB_RD_FLAG = 16'h0080;
  localparam logic [15:0] FAULT_NONE  = 16'h0000;
  localparam logic [15:0] FAULT_UNSUP = 16'h04FF;
  localparam logic [15:0] FAULT_RANGE = 16'h8001;
  localparam logic [22:0] CNT_MAX     = 23'h7FFFFF;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int TB_1US_NS     = 1000;
  localparam int TB_10US_NS    = 10000;
  localparam int TB_100US_NS   = 100000;
  localparam int TB_1MS_NS     = 1000000;
  localparam logic [15:0] CYC_1US  = 16'(TB_1US_NS / CLK_PERIOD_NS);
  localparam logic [15:0] CYC_10US = 16'(TB_10US_NS / CLK_PERIOD_NS);
endpackage : pwt_pkg

// [rtl/pwt_tick_gen.sv]
// Purpose: divide the system clock into time base unit ticks
// Assumes: 50 MHz clock
// Notes:   a change of time base restarts the unit count
`timescale 1ns/1ps
module pwt_tick_gen
  import pwt_pkg::*;
#(
  parameter logic [15:0] CYC_100US = 16'(TB_100US_NS / CLK_PERIOD_NS),
  parameter logic [15:0] CYC_1MS   = 16'(TB_1MS_NS / CLK_PERIOD_NS)
) (
  input  wire logic clk_in,    // system clock
  input  wire logic reset_in,  // sync reset, active high
  pwt_tick_if.gen   tick_if    // time base select and tick
);
  logic [15:0] div_r;
  logic [1:0]  sel_q_r;

  // cycles per unit for each time base code
  function automatic logic [15:0] unit_cycles(input logic [1:0] sel);
    case (sel)
      TB_1MS:  unit_cycles = CYC_1MS;
      TB_1US:  unit_cycles = CYC_1US;
      TB_10US: unit_cycles = CYC_10US;
      default: unit_cycles = CYC_100US;
    endcase
  endfunction : unit_cycles

  // ---------------------------------------------------------------
  // divider
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in || sel_q_r != tick_if.tb_sel) begin
      div_r        <= 16'h0000;
      tick_if.tick <= 1'b0;
    end else if (div_r + 16'h0001 >= unit_cycles(tick_if.tb_sel)) begin
      div_r        <= 16'h0000;
      tick_if.tick <= 1'b1;
    end else begin
      div_r        <= div_r + 16'h0001;
      tick_if.tick <= 1'b0;
    end
  end

  // remember last selection so a change restarts the unit
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      sel_q_r <= TB_RST;
    end else begin
      sel_q_r <= tick_if.tb_sel;
    end
  end
endmodule : pwt_tick_gen

// [rtl/pwt_tick_if.sv]
// Purpose: time base selection and unit tick between core and tick generator
// Assumes: single clock domain
// Notes:   tick is a one-cycle pulse per time base unit
`timescale 1ns/1ps
interface pwt_tick_if;
  logic [1:0] tb_sel;
  logic       tick;
  modport core (output tb_sel, input tick);
  modport gen  (input tb_sel, output tick);
endinterface : pwt_tick_if

// [rtl/pwt_top.sv]
// Purpose: pulse width / pulse train output channel with APB job interface
// Assumes: APB master per AMBA; one clock; no interrupt line
// Notes:   pready follows one wait-free setup; writes land at access edge
`timescale 1ns/1ps
module pwt_top
  import pwt_pkg::*;
#(
  parameter logic [15:0] CYC_100US = 16'(TB_100US_NS / CLK_PERIOD_NS),
  parameter logic [15:0] CYC_1MS   = 16'(TB_1MS_NS / CLK_PERIOD_NS)
) (
  input  wire logic        clk_in,             // system clock, 50 MHz
  input  wire logic        reset_in,           // sync reset, active high
  input  wire logic        psel_in,            // apb select
  input  wire logic        penable_in,         // apb enable
  input  wire logic        pwrite_in,          // apb direction
  input  wire logic [7:0]  paddr_in,           // apb byte address
  input  wire logic [31:0] pwdata_in,          // apb write data
  output logic      [31:0] prdata_out,         // apb read data
  output logic             pready_out,         // apb ready
  output logic             pslverr_out,        // apb error, unmapped address
  output logic             pwm_out,            // digital output channel
  output logic             gate_state_out,     // internal gate open
  output logic             count_disable_out   // channel counter disabled
);
  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_RUN, ST_END} pwt_state_type;

  pwt_tick_if tick_if ();
  pwt_state_type st_r;
  logic [2:0]  ctrl_r;
  logic [15:0] duty_r, job_code_r, fault_r, period_r, delay_r, minp_r, period2_r;
  logic [31:0] job_wval_r, job_rval_r, rdata_nxt;
  logic [22:0] cnt1_r, cnt2_r, left_r;
  logic [1:0]  tb_r;
  logic        req_q_r, busy_r, done_r, err_r, gate_q_r, on_job2_r, train_r;
  logic [15:0] tcnt_r, cur_period_r, cur_pulse_r, sel_period;
  logic        wr_en, addr_ok, gate, period_end, code_ok, val_ok;

  assign tick_if.tb_sel = tb_r;
  assign gate           = ctrl_r[CTRL_GATE_BIT];
  assign wr_en          = psel_in && penable_in && pready_out && pwrite_in;

  pwt_tick_gen #(
    .CYC_100US (CYC_100US),
    .CYC_1MS   (CYC_1MS)
  ) u_tick (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .tick_if  (tick_if)
  );

  // pulse length from duty and period, then minimum pulse filtering
  function automatic logic [15:0] pulse_len(input logic [15:0] per, input logic [15:0] duty,
                                           input logic fmt, input logic [15:0] minp);
    logic [31:0] prod;
    logic [15:0] len;
    prod = 32'(per) * 32'(duty);
    len  = 16'(prod / 32'(fmt ? SCALE_ANALOG : SCALE_PERMIL));
    if (len > per) len = per;
    if (len < minp) len = 16'h0000;
    else if (per - len < minp) len = per;
    pulse_len = len;
  endfunction : pulse_len

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  always_comb begin
    addr_ok   = 1'b1;
    rdata_nxt = 32'h0000_0000;
    case (paddr_in)
      ADDR_CTRL:  rdata_nxt = {29'h0, ctrl_r};
      ADDR_DUTY:  rdata_nxt = {16'h0000, duty_r};
      ADDR_JCODE: rdata_nxt = {16'h0000, job_code_r};
      ADDR_JWVAL: rdata_nxt = job_wval_r;
      ADDR_STAT:  rdata_nxt = {fault_r, 11'h000, st_r != ST_IDLE, train_r, gate_q_r,
                               err_r, done_r};
      ADDR_JRVAL: rdata_nxt = job_rval_r;
      default:    addr_ok = 1'b0;
    endcase
  end

  // one setup cycle, then ready; data and error captured with it
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pready_out  <= 1'b0;
      prdata_out  <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else begin
      pready_out  <= psel_in && !penable_in;
      prdata_out  <= (psel_in && !penable_in && !pwrite_in) ? rdata_nxt : 32'h0000_0000;
      pslverr_out <= psel_in && !penable_in && !addr_ok;
    end
  end

  // software registers
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ctrl_r     <= 3'h0;
      duty_r     <= 16'h0000;
      job_code_r <= JOB_NOP;
      job_wval_r <= 32'h0000_0000;
    end else if (wr_en) begin
      case (paddr_in)
        ADDR_CTRL:  ctrl_r     <= pwdata_in[2:0];
        ADDR_DUTY:  duty_r     <= pwdata_in[15:0];
        ADDR_JCODE: job_code_r <= pwdata_in[15:0];
        ADDR_JWVAL: job_wval_r <= pwdata_in;
        default:    ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // job engine
  // ---------------------------------------------------------------
  // the job is taken on the edge with the code and value standing then
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      req_q_r <= 1'b0;
      busy_r  <= 1'b0;
    end else begin
      req_q_r <= ctrl_r[CTRL_REQ_BIT];
      busy_r  <= ctrl_r[CTRL_REQ_BIT] && !req_q_r;
    end
  end

  // validity of code and value
  always_comb begin
    code_ok = 1'b1;
    val_ok  = 1'b1;
    case (job_code_r & ~JOB_RD_FLAG)
      JOB_PERIOD, JOB_PERIOD2: val_ok = job_wval_r != 0 && job_wval_r <= 32'h0000_FFFF;
      JOB_DELAY: val_ok = job_wval_r <= 32'h0000_FFFF;
      // the 0.1ms base has a floor of two units, equal to the default
      JOB_MINP:  val_ok = job_wval_r <= {17'h0, period_r[15:1]} &&
                          (tb_r != TB_100US || job_wval_r >= {16'h0000, MINP_RST});
      JOB_CNT1, JOB_CNT2: val_ok = job_wval_r <= {9'h0, CNT_MAX};
      JOB_TBASE: val_ok = job_wval_r <= 32'h0000_0003;
      JOB_NOP:   code_ok = job_code_r == JOB_NOP;
      default:   code_ok = 1'b0;
    endcase
    if ((job_code_r & JOB_RD_FLAG) != 16'h0000) begin
      val_ok = 1'b1;
    end
    if (job_code_r[15:8] != 8'h00) begin
      code_ok = 1'b0;
    end
  end

  // done low for the executing cycle; unsupported codes fault
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      done_r  <= 1'b1;
      err_r   <= 1'b0;
      fault_r <= FAULT_NONE;
    end else if (ctrl_r[CTRL_REQ_BIT] && !req_q_r) begin
      done_r <= 1'b0;
    end else if (busy_r) begin
      done_r  <= 1'b1;
      err_r   <= !code_ok || !val_ok;
      fault_r <= !code_ok ? FAULT_UNSUP : (!val_ok ? FAULT_RANGE : FAULT_NONE);
    end
  end

  // parameter writes and reads; periods and minimum pulse act at next period, time base at once
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      period_r   <= PERIOD_RST;
      delay_r    <= DELAY_RST;
      minp_r     <= MINP_RST;
      period2_r  <= PERIOD_RST;
      cnt1_r     <= 23'h0;
      cnt2_r     <= 23'h0;
      tb_r       <= TB_RST;
      job_rval_r <= 32'h0000_0000;
    end else if (busy_r && code_ok && val_ok) begin
      case (job_code_r)
        JOB_PERIOD:  period_r  <= job_wval_r[15:0];
        JOB_DELAY:   delay_r   <= job_wval_r[15:0];
        JOB_MINP:    minp_r    <= job_wval_r[15:0];
        JOB_CNT1:    cnt1_r    <= job_wval_r[22:0];
        JOB_CNT2:    cnt2_r    <= job_wval_r[22:0];
        JOB_PERIOD2: period2_r <= job_wval_r[15:0];
        JOB_TBASE:   tb_r      <= job_wval_r[1:0];
        JOB_PERIOD | JOB_RD_FLAG:  job_rval_r <= {16'h0000, period_r};
        JOB_DELAY | JOB_RD_FLAG:   job_rval_r <= {16'h0000, delay_r};
        JOB_MINP | JOB_RD_FLAG:    job_rval_r <= {16'h0000, minp_r};
        JOB_CNT1 | JOB_RD_FLAG:    job_rval_r <= {9'h0, cnt1_r};
        JOB_CNT2 | JOB_RD_FLAG:    job_rval_r <= {9'h0, cnt2_r};
        JOB_PERIOD2 | JOB_RD_FLAG: job_rval_r <= {16'h0000, period2_r};
        JOB_TBASE | JOB_RD_FLAG:   job_rval_r <= {30'h0, tb_r};
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // output sequencer
  // ---------------------------------------------------------------
  assign sel_period = on_job2_r ? period2_r : period_r;
  assign period_end = tick_if.tick && (tcnt_r + 16'h0001 >= cur_period_r);

  // gate edge, mode capture; train chosen by nonzero pulse count
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      gate_q_r <= 1'b0;
      train_r  <= 1'b0;
    end else begin
      gate_q_r <= gate;
      if (gate && !gate_q_r) begin
        train_r <= cnt1_r != 23'h0 || cnt2_r != 23'h0;
      end
    end
  end

  // state, unit counter and per-period latches; closing the gate stops at once
  always_ff @(posedge clk_in) begin
    if (reset_in || !gate) begin
      st_r         <= ST_IDLE;
      tcnt_r       <= 16'h0000;
      cur_period_r <= PERIOD_RST;
      cur_pulse_r  <= 16'h0000;
      left_r       <= 23'h0;
      on_job2_r    <= 1'b0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (!gate_q_r) begin
            st_r   <= ST_DELAY;
            tcnt_r <= 16'h0000;
            left_r <= cnt1_r != 23'h0 ? cnt1_r : cnt2_r;
            on_job2_r <= cnt1_r == 23'h0 && cnt2_r != 23'h0;
          end
        end
        ST_DELAY: begin
          if (tcnt_r >= delay_r) begin
            st_r         <= ST_RUN;
            tcnt_r       <= 16'h0000;
            cur_period_r <= sel_period;
            cur_pulse_r  <= pulse_len(sel_period, duty_r, ctrl_r[CTRL_FMT_BIT], minp_r);
          end else if (tick_if.tick) begin
            tcnt_r <= tcnt_r + 16'h0001;
          end
        end
        ST_RUN: begin
          if (period_end) begin
            tcnt_r <= 16'h0000;
            if (train_r && left_r <= 23'h1) begin
              if (!on_job2_r && cnt2_r != 23'h0) begin
                on_job2_r    <= 1'b1;
                left_r       <= cnt2_r;
                cur_period_r <= period2_r;
                cur_pulse_r  <= pulse_len(period2_r, duty_r, ctrl_r[CTRL_FMT_BIT], minp_r);
              end else begin
                st_r <= ST_END;
              end
            end else begin
              left_r       <= left_r - 23'h1;
              cur_period_r <= sel_period;
              cur_pulse_r  <= pulse_len(sel_period, duty_r, ctrl_r[CTRL_FMT_BIT], minp_r);
            end
          end else if (tick_if.tick) begin
            tcnt_r <= tcnt_r + 16'h0001;
          end
        end
        ST_END: st_r <= ST_END;
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // registered outputs; no interrupt path exists for this function
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pwm_out           <= 1'b0;
      gate_state_out    <= 1'b0;
      count_disable_out <= 1'b0;
    end else begin
      pwm_out           <= gate && st_r == ST_RUN && tcnt_r < cur_pulse_r;
      gate_state_out    <= gate;
      count_disable_out <= gate;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  a_gate_closed_low: assert property (!gate |=> !pwm_out)
    else $error("output active with gate closed");
  a_delay_low: assert property (st_r == ST_DELAY |=> !pwm_out)
    else $error("output active during on-delay");
  a_gate_report: assert property (gate |=> gate_state_out ##0 count_disable_out)
    else $error("gate state or counter disable not reported");
  a_done_drop: assert property ($rose(ctrl_r[CTRL_REQ_BIT]) |=> !done_r ##1 done_r)
    else $error("job done did not pulse low for one cycle");
  a_no_retrigger: assert property (ctrl_r[CTRL_REQ_BIT] && req_q_r |=> !busy_r)
    else $error("job taken without a request edge");
  a_unsup_fault: assert property (busy_r && !code_ok |=> err_r && fault_r == FAULT_UNSUP)
    else $error("unsupported job not faulted with 04FF");
  a_good_job: assert property (busy_r && code_ok && val_ok |=> !err_r && fault_r == FAULT_NONE)
    else $error("successful job reported a fault");
  a_period_hold: assert property (st_r == ST_RUN && !period_end && gate |=> $stable(cur_period_r))
    else $error("period changed mid-period");
  a_pulse_fit: assert property (st_r == ST_RUN |-> cur_pulse_r <= cur_period_r)
    else $error("pulse longer than period");
  a_train_sel: assert property ($rose(gate) && cnt1_r != 23'h0 |=> train_r)
    else $error("pulse train mode not selected");
endmodule : pwt_top
